// [rtl/dapm_host.sv]
// Host controller that frames conversions and power modes on a serial port.
`timescale 1ns/1ps
// How it works
// R1: Hold select low ten falls for normal.
// R2: Rise between ten and fourteen aborts, stays up.
// R3: Fourteen clocks give one result word.
// R4: Two more clocks give trailing zeros.
// R5: Further clocks give the other result.
// R6: Output floats at falling edge thirty-two.
// R7: Wait idle gap before next select fall.
// R8: Rise in two-to-ten window enters partial.
// R9: Rise before second fall keeps normal.
// R10: Partial mode keeps only reference powered.
// R11: Dummy cycle wakes partial in one microsecond.
// R12: Early rise in partial stays partial.
// R13: Wake starts at fall, early rise stops.
// R14: Window rise in partial enters full.
// R15: Two window aborts reach full power-down.
// R16: Power-down needs no clocks past the abort.
// R17: Full wake waits deep wake time.
// R18: Short wake needs partial at least 67 us.
// R19: After supply-up run one dummy cycle.
// R20: Two dummy cycles hold partial.
// R21: Three dummy cycles reach full.
// R22: Select fall starts conversion, drives data.
// R23: Word is two zeros then twelve bits.
// R24: Falling edge with select fall not counted.
// R25: Mode tracked, edges counted per frame.
// R26: Edge count saturates at thirty-two.
module dapm_host #(
  parameter int DEEP_WAKE_CYCLES = dapm_pkg::DEEP_WAKE_CYC,
  parameter int PARTIAL_SETTLE_CYCLES = dapm_pkg::PARTIAL_SETTLE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_code,
  input wire logic cmd_dual,
  input wire logic cmd_pad,
  output logic cmd_ready,
  output logic [11:0] result_first,
  output logic [11:0] result_second,
  output logic result_valid,
  output logic [1:0] power_mode,
  output logic conv_sel_n,
  output logic serial_clk,
  input wire logic result_out_first,
  input wire logic result_out_second
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] sync_a_r;
  logic [1:0] sync_b_r;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sync_a_r <= 2'h0;
      sync_b_r <= 2'h0;
    end
    else
    begin
      sync_a_r <= {sync_a_r[0], result_out_first};
      sync_b_r <= {sync_b_r[0], result_out_second};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  dapm_pkg::dapm_state_t st_r, st_nxt;
  dapm_pkg::dapm_mode_t mode_r, mode_nxt;
  dapm_pkg::dapm_cmd_t cmd_r, cmd_nxt;
  logic [5:0] edges_r, edges_nxt;
  logic [5:0] stop_r, stop_nxt;
  logic [3:0] div_r, div_nxt;
  logic [31:0] wait_r, wait_nxt;
  logic [31:0] settle_r, settle_nxt;
  logic [31:0] sh_a_r, sh_a_nxt;
  logic [31:0] sh_b_r, sh_b_nxt;
  logic sel_n_r, sel_n_nxt;
  logic sclk_r, sclk_nxt;
  logic rdy_r, rdy_nxt;
  logic rv_r, rv_nxt;
  logic [11:0] ra_r, ra_nxt;
  logic [11:0] rb_r, rb_nxt;
  logic dual_r, dual_nxt;
  always_comb
  begin
    st_nxt = st_r;
    mode_nxt = mode_r;
    cmd_nxt = cmd_r;
    edges_nxt = edges_r;
    stop_nxt = stop_r;
    div_nxt = div_r;
    wait_nxt = wait_r;
    settle_nxt = (settle_r != 32'h0) ? settle_r - 32'h1 : settle_r;
    sh_a_nxt = sh_a_r;
    sh_b_nxt = sh_b_r;
    sel_n_nxt = sel_n_r;
    sclk_nxt = sclk_r;
    rdy_nxt = rdy_r;
    rv_nxt = 1'b0;
    ra_nxt = ra_r;
    rb_nxt = rb_r;
    dual_nxt = dual_r;
    case (st_r)
      dapm_pkg::DAPM_IDLE:
      begin
        if (cmd_valid && rdy_r)
        begin
          cmd_nxt = dapm_pkg::dapm_cmd_t'(cmd_code);
          dual_nxt = cmd_dual;
          // R22: Select fall opens frame.
          sel_n_nxt = 1'b0;
          rdy_nxt = 1'b0;
          edges_nxt = 6'h00;
          div_nxt = 4'h0;
          // R16: Power-down frames stop early.
          case (dapm_pkg::dapm_cmd_t'(cmd_code))
            dapm_pkg::DAPM_CMD_PARTIAL,
            dapm_pkg::DAPM_CMD_FULL: stop_nxt = dapm_pkg::EDGE_PD_ABORT;
            dapm_pkg::DAPM_CMD_WAKE: stop_nxt = dapm_pkg::EDGE_STAY_UP;
            default:
              stop_nxt = cmd_dual ? dapm_pkg::EDGE_DUAL :
                (cmd_pad ? dapm_pkg::EDGE_WORD_PAD : dapm_pkg::EDGE_WORD);
          endcase
          st_nxt = dapm_pkg::DAPM_LOW;
        end
      end
      dapm_pkg::DAPM_LOW, dapm_pkg::DAPM_CLKH:
      begin
        div_nxt = div_r + 4'h1;
        if (div_r == dapm_pkg::SCLK_HALF)
        begin
          // R24: Clock rises first, so no fall meets select fall.
          div_nxt = 4'h0;
          sclk_nxt = 1'b1;
          st_nxt = dapm_pkg::DAPM_CLKL;
        end
      end
      dapm_pkg::DAPM_CLKL:
      begin
        div_nxt = div_r + 4'h1;
        if (div_r == dapm_pkg::SCLK_HALF)
        begin
          div_nxt = 4'h0;
          sclk_nxt = 1'b0;
          // R23: Sample the bit held since the previous fall.
          sh_a_nxt = {sh_a_r[30:0], sync_a_r[1]};
          sh_b_nxt = {sh_b_r[30:0], sync_b_r[1]};
          // R26: Count saturates at thirty-two.
          if (edges_r != dapm_pkg::EDGE_DUAL)
            edges_nxt = edges_r + 6'h01;
          st_nxt = dapm_pkg::DAPM_CLKH;
          if (edges_r + 6'h01 >= stop_r)
          begin
            st_nxt = dapm_pkg::DAPM_GAP;
            wait_nxt = 32'(dapm_pkg::BUS_IDLE_GAP_CYC);
          end
        end
      end
      dapm_pkg::DAPM_GAP:
      begin
        // Select rises one reference clock after the last fall.
        // Raising it on the fall itself races the device's edge count.
        sel_n_nxt = 1'b1;
        // R25: Mode updated at the select rise.
        case (cmd_r)
          // R8: Window rise from normal gives partial.
          // R14: Window rise from partial gives full.
          // R15: Second window abort reaches full.
          dapm_pkg::DAPM_CMD_PARTIAL, dapm_pkg::DAPM_CMD_FULL:
          begin
            mode_nxt = (mode_r == dapm_pkg::DAPM_PARTIAL ||
              mode_r == dapm_pkg::DAPM_FULL) ? dapm_pkg::DAPM_FULL :
              dapm_pkg::DAPM_PARTIAL;
            settle_nxt = 32'(PARTIAL_SETTLE_CYCLES);
            if (cmd_r == dapm_pkg::DAPM_CMD_FULL &&
              mode_r != dapm_pkg::DAPM_PARTIAL &&
              mode_r != dapm_pkg::DAPM_FULL)
            begin
              // R21: Another window abort follows.
              cmd_nxt = dapm_pkg::DAPM_CMD_FULL;
            end
          end
          default:
          begin
            // R11: Wake from partial takes about one microsecond.
            // R17: Wake from full takes the deep wake time.
            // R18: Settle time not met means deep wait.
            if (mode_r == dapm_pkg::DAPM_FULL ||
              mode_r == dapm_pkg::DAPM_UNKNOWN || settle_r != 32'h0)
              wait_nxt = 32'(DEEP_WAKE_CYCLES);
            else if (mode_r == dapm_pkg::DAPM_PARTIAL)
              wait_nxt = 32'(dapm_pkg::PARTIAL_WAKE_CYC);
            mode_nxt = dapm_pkg::DAPM_NORMAL;
            if (cmd_r == dapm_pkg::DAPM_CMD_CONVERT &&
              mode_r == dapm_pkg::DAPM_NORMAL)
            begin
              // R3: Result word from bits after two zeros.
              if (dual_r)
              begin
                // R5: Both results on the first line.
                ra_nxt = sh_a_r[29:18];
                rb_nxt = sh_a_r[13:2];
              end
              else if (stop_r == dapm_pkg::EDGE_WORD)
              begin
                ra_nxt = sh_a_r[11:0];
                rb_nxt = sh_b_r[11:0];
              end
              else
              begin
                // R4: Two trailing zeros dropped.
                ra_nxt = sh_a_r[13:2];
                rb_nxt = sh_b_r[13:2];
              end
              rv_nxt = 1'b1;
            end
          end
        endcase
        st_nxt = dapm_pkg::DAPM_WAIT;
      end
      dapm_pkg::DAPM_WAIT:
      begin
        // R7: Idle gap before next select fall.
        if (wait_r != 32'h0)
          wait_nxt = wait_r - 32'h1;
        else if (cmd_r == dapm_pkg::DAPM_CMD_FULL &&
          mode_r == dapm_pkg::DAPM_PARTIAL)
        begin
          sel_n_nxt = 1'b0;
          edges_nxt = 6'h00;
          div_nxt = 4'h0;
          stop_nxt = dapm_pkg::EDGE_PD_ABORT;
          st_nxt = dapm_pkg::DAPM_LOW;
        end
        else
        begin
          rdy_nxt = 1'b1;
          st_nxt = dapm_pkg::DAPM_IDLE;
        end
      end
      default: st_nxt = dapm_pkg::DAPM_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= dapm_pkg::DAPM_IDLE;
      // R19: Mode unknown after supply-up.
      mode_r <= dapm_pkg::DAPM_UNKNOWN;
      cmd_r <= dapm_pkg::DAPM_CMD_CONVERT;
      edges_r <= 6'h00;
      stop_r <= 6'h00;
      div_r <= 4'h0;
      wait_r <= 32'h0;
      settle_r <= 32'h0;
      sh_a_r <= 32'h0;
      sh_b_r <= 32'h0;
      sel_n_r <= 1'b1;
      sclk_r <= 1'b0;
      rdy_r <= 1'b1;
      rv_r <= 1'b0;
      ra_r <= 12'h000;
      rb_r <= 12'h000;
      dual_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      cmd_r <= cmd_nxt;
      edges_r <= edges_nxt;
      stop_r <= stop_nxt;
      div_r <= div_nxt;
      wait_r <= wait_nxt;
      settle_r <= settle_nxt;
      sh_a_r <= sh_a_nxt;
      sh_b_r <= sh_b_nxt;
      sel_n_r <= sel_n_nxt;
      sclk_r <= sclk_nxt;
      rdy_r <= rdy_nxt;
      rv_r <= rv_nxt;
      ra_r <= ra_nxt;
      rb_r <= rb_nxt;
      dual_r <= dual_nxt;
    end
  end
  assign cmd_ready = rdy_r;
  assign result_first = ra_r;
  assign result_second = rb_r;
  assign result_valid = rv_r;
  assign power_mode = mode_r;
  assign conv_sel_n = sel_n_r;
  assign serial_clk = sclk_r;
  ////////////////////////////////////////////////////////////////////////////
  AST_SEL_STEADY_IN_FRAME: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r == dapm_pkg::DAPM_CLKH) |-> !conv_sel_n) // R1
    else $error("Select high inside a frame.");
  AST_PD_ABORT_WINDOW: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(conv_sel_n) && (cmd_r == dapm_pkg::DAPM_CMD_PARTIAL)) |->
    (edges_r >= dapm_pkg::EDGE_MIN_ABORT && edges_r < dapm_pkg::EDGE_STAY_UP))
    // R8
    else $error("Power-down abort outside the window.");
  AST_CONVERT_LEN: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(conv_sel_n) && cmd_r == dapm_pkg::DAPM_CMD_CONVERT) |->
    edges_r >= dapm_pkg::EDGE_WORD) // R3
    else $error("Conversion frame too short.");
  AST_COUNT_SAT: assert property (@(posedge ref_clk) disable iff (rst)
    edges_r <= dapm_pkg::EDGE_DUAL) // R26
    else $error("Edge count above thirty-two.");
  AST_WAKE_NORMAL: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r == dapm_pkg::DAPM_GAP && cmd_r == dapm_pkg::DAPM_CMD_WAKE) |=>
    power_mode == dapm_pkg::DAPM_NORMAL) // R11
    else $error("Wake did not restore normal.");
  AST_FULL_FROM_PARTIAL: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r == dapm_pkg::DAPM_GAP && (cmd_r == dapm_pkg::DAPM_CMD_PARTIAL ||
    cmd_r == dapm_pkg::DAPM_CMD_FULL) && mode_r == dapm_pkg::DAPM_PARTIAL)
    |=> power_mode == dapm_pkg::DAPM_FULL)
    // R14
    else $error("Second abort did not reach full.");
  AST_GAP_HELD: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(conv_sel_n) |=> conv_sel_n [*2]) // R7
    else $error("Select fell again too soon.");
  AST_SCLK_IDLE_LOW: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(conv_sel_n) |-> !serial_clk) // R24
    else $error("Clock high at select fall.");
endmodule

// [pkg/dapm_pkg.sv]
// Package of constants and types for the dual converter power-mode host.
package dapm_pkg;
  // Serial clock falling-edge counts that frame a select-low period.
  localparam logic [5:0] EDGE_MIN_ABORT = 6'h02;
  localparam logic [5:0] EDGE_STAY_UP = 6'h0A;
  localparam logic [5:0] EDGE_WORD = 6'h0E;
  localparam logic [5:0] EDGE_WORD_PAD = 6'h10;
  localparam logic [5:0] EDGE_DUAL = 6'h20;
  // Early abort point used to enter a power-down mode.
  localparam logic [5:0] EDGE_PD_ABORT = 6'h05;
  // Serial clock divider: last divider count of a half period, which lasts SCLK_HALF plus one reference clocks.
  localparam logic [3:0] SCLK_HALF = 4'h2;
  // Timing, in the units printed, and the derived cycle counts at 40 MHz.
  localparam int REF_CLK_MHZ = 40;
  localparam int BUS_IDLE_GAP_NS = 60;
  localparam int BUS_IDLE_GAP_CYC = (BUS_IDLE_GAP_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int PARTIAL_WAKE_NS = 1000;
  localparam int PARTIAL_WAKE_CYC = (PARTIAL_WAKE_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int DEEP_WAKE_TIME_US = 1500;
  localparam int DEEP_WAKE_CYC = DEEP_WAKE_TIME_US * REF_CLK_MHZ;
  localparam int PARTIAL_SETTLE_US = 67;
  localparam int PARTIAL_SETTLE_CYC = PARTIAL_SETTLE_US * REF_CLK_MHZ;
  // Power mode that the host believes the device is in.
  typedef enum logic [1:0] {
    DAPM_NORMAL = 2'b00,
    DAPM_PARTIAL = 2'b01,
    DAPM_FULL = 2'b10,
    DAPM_UNKNOWN = 2'b11
  } dapm_mode_t;
  // Host commands.
  typedef enum logic [1:0] {
    DAPM_CMD_CONVERT = 2'b00,
    DAPM_CMD_PARTIAL = 2'b01,
    DAPM_CMD_FULL = 2'b10,
    DAPM_CMD_WAKE = 2'b11
  } dapm_cmd_t;
  typedef enum logic [2:0] {
    DAPM_IDLE = 3'b000,
    DAPM_LOW = 3'b001,
    DAPM_CLKH = 3'b010,
    DAPM_CLKL = 3'b011,
    DAPM_GAP = 3'b100,
    DAPM_WAIT = 3'b101
  } dapm_state_t;
endpackage

// [test/dapm_dev_model.sv]
// Behavioural model of the dual converter behind the select-framed port.
`timescale 1ns/1ps
module dapm_dev_model #(
  parameter int CLK_NS = 25
) (
  input wire logic conv_sel_n,
  input wire logic serial_clk,
  input wire logic [11:0] val_a,
  input wire logic [11:0] val_b,
  output logic result_out_first,
  output logic result_out_second,
  output dapm_pkg::dapm_mode_t dev_mode,
  output logic [5:0] edges,
  output int gap_cyc,
  output int per_cyc
);
  logic [31:0] word_a;
  logic [31:0] word_b;
  time last_fall;
  time last_rise;
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    dev_mode = dapm_pkg::DAPM_PARTIAL;
    edges = 6'h00;
    last_fall = 0;
    last_rise = 0;
    result_out_first = 1'b1;
    result_out_second = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Fall samples, clears the count, drives a zero.
  always @(negedge conv_sel_n)
  begin
    gap_cyc = int'(($time - last_rise) / CLK_NS);
    per_cyc = int'(($time - last_fall) / CLK_NS);
    last_fall = $time;
    edges = 6'h00;
    word_a = {2'b00, val_a, 4'h0, val_b, 2'b00};
    word_b = {2'b00, val_b, 4'h0, val_a, 2'b00};
    result_out_first = word_a[31];
    result_out_second = word_b[31];
  end
  // Each fall shifts a bit; line floats at the 32nd.
  always @(negedge serial_clk)
    if (!conv_sel_n && edges != 6'h20)
    begin
      edges = edges + 6'h01;
      if (edges == 6'h20)
      begin
        result_out_first = ~result_out_first;
        result_out_second = ~result_out_second;
      end
      else
      begin
        result_out_first = word_a[31 - edges];
        result_out_second = word_b[31 - edges];
      end
    end
  // Rise floats lines and picks the mode.
  always @(posedge conv_sel_n)
  begin
    last_rise = $time;
    result_out_first = ~result_out_first;
    result_out_second = ~result_out_second;
    if (edges >= 6'h0A)
      dev_mode = dapm_pkg::DAPM_NORMAL;
    else if (edges >= 6'h02)
      dev_mode = (dev_mode == dapm_pkg::DAPM_NORMAL) ?
        dapm_pkg::DAPM_PARTIAL : dapm_pkg::DAPM_FULL;
  end
endmodule

// [test/dual_adc_power_mode_ctrl_tb_top.sv]
// Self-checking bench for the power-mode host with a converter model.
`timescale 1ns/1ps
module dual_adc_power_mode_ctrl_tb_top;
  localparam int DEEP = 20;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_code = 2'b00;
  logic cmd_dual = 1'b0;
  logic cmd_pad = 1'b0;
  logic [11:0] val_a = 12'h000;
  logic [11:0] val_b = 12'h000;
  logic cmd_ready, result_valid, conv_sel_n, serial_clk, got_valid;
  logic dout_a, dout_b;
  logic [11:0] result_first, result_second;
  logic [1:0] power_mode;
  logic [5:0] edges;
  dapm_pkg::dapm_mode_t dev_mode;
  int gap_cyc, per_cyc, n_mismatch = 0, check_count = 0;
  ////////////////////////////////////////////////////////////////////////////
  always #12.5 ref_clk = ~ref_clk;
  dapm_host #(.DEEP_WAKE_CYCLES(DEEP), .PARTIAL_SETTLE_CYCLES(10)) i_dapm_host (
    .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_dual(cmd_dual), .cmd_pad(cmd_pad),
    .cmd_ready(cmd_ready), .result_first(result_first),
    .result_second(result_second), .result_valid(result_valid),
    .power_mode(power_mode), .conv_sel_n(conv_sel_n),
    .serial_clk(serial_clk), .result_out_first(dout_a),
    .result_out_second(dout_b));
  dapm_dev_model i_dapm_dev_model (
    .conv_sel_n(conv_sel_n), .serial_clk(serial_clk), .val_a(val_a),
    .val_b(val_b), .result_out_first(dout_a), .result_out_second(dout_b),
    .dev_mode(dev_mode), .edges(edges), .gap_cyc(gap_cyc),
    .per_cyc(per_cyc));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [5:0] exp_edges(input logic d, input logic p);
    return d ? dapm_pkg::EDGE_DUAL :
      (p ? dapm_pkg::EDGE_WORD_PAD : dapm_pkg::EDGE_WORD);
  endfunction
  // Issues one command and waits, bounded, until the host is idle again.
  task automatic run_cmd(input logic [1:0] c, input logic d, input logic p);
    int n;
    got_valid = 1'b0;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_dual <= d;
    cmd_pad <= p;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (result_valid === 1'b1)
        got_valid = 1'b1;
    end
    while (cmd_ready !== 1'b1 && n < 4000);
    check(n < 4000, 1'b1);
  endtask
  task automatic check_mode(input dapm_pkg::dapm_mode_t m);
    check(power_mode, m);
    check(dev_mode, m);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #500000;
    n_mismatch++;
    close_out();
  end
  initial
  begin
    logic d, p;
    void'($urandom(32'h56FF));
    repeat (12) @(posedge ref_clk);
    check({conv_sel_n, serial_clk, cmd_ready, result_valid}, 4'hA);
    check(power_mode, dapm_pkg::DAPM_UNKNOWN);
    rst <= 1'b0;
    @(posedge ref_clk);
    run_cmd(dapm_pkg::DAPM_CMD_WAKE, 1'b0, 1'b0);
    check(edges >= dapm_pkg::EDGE_STAY_UP, 1'b1);
    check_mode(dapm_pkg::DAPM_NORMAL);
    for (int i = 0; i < 10; i++)
    begin
      d = (i == 1) ? 1'b1 : 1'(i > 2 ? $urandom : 0);
      p = d | (i == 2) | 1'($urandom);
      val_a <= (i == 0) ? 12'hFFF : 12'($urandom);
      val_b <= (i == 0) ? 12'h000 : 12'($urandom);
      run_cmd(dapm_pkg::DAPM_CMD_CONVERT, d, p);
      check(got_valid, 1'b1);
      check(result_first, val_a);
      check(result_second, val_b);
      check(edges, exp_edges(d, p));
      check(gap_cyc >= dapm_pkg::BUS_IDLE_GAP_CYC, 1'b1);
      check_mode(dapm_pkg::DAPM_NORMAL);
    end
    run_cmd(dapm_pkg::DAPM_CMD_PARTIAL, 1'b0, 1'b0);
    check(edges, dapm_pkg::EDGE_PD_ABORT);
    check_mode(dapm_pkg::DAPM_PARTIAL);
    run_cmd(dapm_pkg::DAPM_CMD_CONVERT, 1'b0, 1'b0);
    check(per_cyc >= 10, 1'b1);
    check(got_valid, 1'b0);
    check_mode(dapm_pkg::DAPM_NORMAL);
    run_cmd(dapm_pkg::DAPM_CMD_CONVERT, 1'b0, 1'b0);
    check(per_cyc >= dapm_pkg::PARTIAL_WAKE_CYC, 1'b1);
    check(got_valid, 1'b1);
    run_cmd(dapm_pkg::DAPM_CMD_FULL, 1'b0, 1'b0);
    check(edges, dapm_pkg::EDGE_PD_ABORT);
    check_mode(dapm_pkg::DAPM_FULL);
    run_cmd(dapm_pkg::DAPM_CMD_WAKE, 1'b0, 1'b0);
    check(edges >= dapm_pkg::EDGE_STAY_UP, 1'b1);
    check_mode(dapm_pkg::DAPM_NORMAL);
    val_a <= 12'h5A5;
    run_cmd(dapm_pkg::DAPM_CMD_CONVERT, 1'b0, 1'b1);
    check(per_cyc >= DEEP, 1'b1);
    check(result_first, 12'h5A5);
    close_out();
  end
endmodule
